// file: rtl/opr_output_clock_pin_routing.sv
// output clock pin routing: clock copies, aux pins, diff pairs, frame syncs
// assumes synthesized clocks and config inputs are synchronous to mclk_in
// Overview of operation
// - aux pins one-three: clock copy or general io
// - aux one-three clock function off after reset
// - aux four-five off, copy when enabled
// - diff four-five copy single-ended, own format
// - diff six-seven default 38.88/19.44 lvds
// - outputs one-four reset default frequencies
// - output five default from rate strap
// - 8k sync defaults to 50% noninverted clock
// - 8k invert and pulse select bits
// - 2k sync clock/pulse with invert, pulse bits
// - strap sampled at reset release
`timescale 1ns/10ps
`default_nettype none
`include "opr_map.svh"
module opr_output_clock_pin_routing #(
    parameter int FRAME_8K_CYCLES = `OPR_FRAME_8K_NS / `OPR_CLK_PERIOD_NS,
    parameter int FRAME_2K_CYCLES = `OPR_FRAME_2K_NS / `OPR_CLK_PERIOD_NS,
    parameter int PULSE_CYCLES    = `OPR_PULSE_CYCLES
) (
    input  wire logic              mclk_in,
    input  wire logic              reset_n_in,
    input  wire logic [6:0]        synth_clock_in,
    input  wire logic              rate_family_strap_in,
    input  wire logic              cfg_wr_in,
    input  wire logic [4:0]        aux_clock_enable_in,
    input  wire logic [7:0]        diff_format_in,
    input  wire logic [3:0]        frame_ctl_in,
    input  wire logic              freq_wr_in,
    input  wire logic [2:0]        freq_idx_in,
    input  wire opr_pkg::opr_khz_t freq_khz_in,
    input  wire logic [2:0]        general_io_drive_in,
    input  wire logic [2:0]        general_io_dir_in,
    input  wire logic [2:0]        general_io_pad_in,
    output logic [2:0]             general_io_read_out,
    output logic                   primary_clock_out_one_out,
    output logic                   primary_clock_out_two_out,
    output logic                   primary_clock_out_three_out,
    output logic                   primary_clock_out_four_out,
    output logic                   primary_clock_out_five_out,
    output logic [4:0]             aux_clock_copy_out,
    output logic [4:0]             aux_clock_copy_oe_n_out,
    output logic [3:0]             diff_clock_plus_out,
    output logic [3:0]             diff_clock_minus_out,
    output opr_pkg::opr_fmt_t      diff_four_format_sel_out,
    output opr_pkg::opr_fmt_t      diff_five_format_sel_out,
    output opr_pkg::opr_fmt_t      diff_six_format_sel_out,
    output opr_pkg::opr_fmt_t      diff_seven_format_sel_out,
    output opr_pkg::opr_khz_t      freq_one_khz_out,
    output opr_pkg::opr_khz_t      freq_two_khz_out,
    output opr_pkg::opr_khz_t      freq_three_khz_out,
    output opr_pkg::opr_khz_t      freq_four_khz_out,
    output opr_pkg::opr_khz_t      freq_five_khz_out,
    output opr_pkg::opr_khz_t      freq_six_khz_out,
    output opr_pkg::opr_khz_t      freq_seven_khz_out,
    output opr_pkg::opr_family_e   rate_family_out,
    output logic                   frame_pulse_8k_out,
    output logic                   multiframe_pulse_2k_out
);

    localparam opr_pkg::opr_cnt_t HALF_8K  = opr_pkg::opr_cnt_t'(FRAME_8K_CYCLES / 2);
    localparam opr_pkg::opr_cnt_t HALF_2K  = opr_pkg::opr_cnt_t'(FRAME_2K_CYCLES / 2);
    localparam opr_pkg::opr_cnt_t LAST_8K  = opr_pkg::opr_cnt_t'(FRAME_8K_CYCLES - 1);
    localparam opr_pkg::opr_cnt_t LAST_2K  = opr_pkg::opr_cnt_t'(FRAME_2K_CYCLES - 1);
    localparam opr_pkg::opr_cnt_t PULSE_W  = opr_pkg::opr_cnt_t'(PULSE_CYCLES);

    logic [4:0]           aux_en_q;
    logic [3:0]           frame_ctl_q;
    logic                 strap_done_q;
    opr_pkg::opr_cnt_t    cnt_8k_q;
    opr_pkg::opr_cnt_t    cnt_2k_q;

    // frame sync level from phase counter, shape and polarity
    function automatic logic frame_level(input opr_pkg::opr_cnt_t cnt,
                                         input opr_pkg::opr_cnt_t half,
                                         input logic pulse, input logic inv);
        logic lvl;
        lvl = pulse ? (cnt < PULSE_W) : (cnt < half);
        return lvl ^ inv;
    endfunction

    // control fields written as one group
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            aux_en_q                  <= `OPR_AUX_EN_RESET;
            frame_ctl_q               <= `OPR_FRAME_CTL_RESET;
            diff_four_format_sel_out  <= `OPR_FMT_LVDS;
            diff_five_format_sel_out  <= `OPR_FMT_LVDS;
            diff_six_format_sel_out   <= `OPR_FMT_LVDS;
            diff_seven_format_sel_out <= `OPR_FMT_LVDS;
        end else if (cfg_wr_in) begin
            aux_en_q                  <= aux_clock_enable_in;
            frame_ctl_q               <= frame_ctl_in;
            diff_four_format_sel_out  <= diff_format_in[1:0];
            diff_five_format_sel_out  <= diff_format_in[3:2];
            diff_six_format_sel_out   <= diff_format_in[5:4];
            diff_seven_format_sel_out <= diff_format_in[7:6];
        end
    end

    // strap caught on first edge after reset release
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            strap_done_q    <= 1'b0;
            rate_family_out <= opr_pkg::OPR_FAMILY_SDH;
        end else if (!strap_done_q) begin
            strap_done_q    <= 1'b1;
            rate_family_out <= rate_family_strap_in ? opr_pkg::OPR_FAMILY_SONET
                                                    : opr_pkg::OPR_FAMILY_SDH;
        end
    end

    // programmable frequencies with reset defaults
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            freq_one_khz_out   <= `OPR_KHZ_6P48;
            freq_two_khz_out   <= `OPR_KHZ_38P88;
            freq_three_khz_out <= `OPR_KHZ_19P44;
            freq_four_khz_out  <= `OPR_KHZ_38P88;
            freq_five_khz_out  <= `OPR_KHZ_2P048;
            freq_six_khz_out   <= `OPR_KHZ_38P88;
            freq_seven_khz_out <= `OPR_KHZ_19P44;
        end else if (!strap_done_q) begin
            freq_five_khz_out  <= rate_family_strap_in ? `OPR_KHZ_1P544
                                                       : `OPR_KHZ_2P048;
        end else if (freq_wr_in) begin
            case (freq_idx_in)
                3'h0:    freq_one_khz_out   <= freq_khz_in;
                3'h1:    freq_two_khz_out   <= freq_khz_in;
                3'h2:    freq_three_khz_out <= freq_khz_in;
                3'h3:    freq_four_khz_out  <= freq_khz_in;
                3'h4:    freq_five_khz_out  <= freq_khz_in;
                3'h5:    freq_six_khz_out   <= freq_khz_in;
                3'h6:    freq_seven_khz_out <= freq_khz_in;
                default: freq_one_khz_out   <= freq_one_khz_out;
            endcase
        end
    end

    // primary copies and differential pairs
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            primary_clock_out_one_out   <= 1'b0;
            primary_clock_out_two_out   <= 1'b0;
            primary_clock_out_three_out <= 1'b0;
            primary_clock_out_four_out  <= 1'b0;
            primary_clock_out_five_out  <= 1'b0;
            diff_clock_plus_out         <= 4'h0;
            diff_clock_minus_out        <= 4'hf;
        end else begin
            primary_clock_out_one_out   <= synth_clock_in[0];
            primary_clock_out_two_out   <= synth_clock_in[1];
            primary_clock_out_three_out <= synth_clock_in[2];
            primary_clock_out_four_out  <= synth_clock_in[3];
            primary_clock_out_five_out  <= synth_clock_in[4];
            diff_clock_plus_out         <= synth_clock_in[6:3];
            diff_clock_minus_out        <= ~synth_clock_in[6:3];
        end
    end

    // aux pins: clock copy, general io, or released
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            aux_clock_copy_out      <= 5'h00;
            aux_clock_copy_oe_n_out <= 5'h1f;
            general_io_read_out     <= 3'h0;
        end else begin
            general_io_read_out <= general_io_pad_in;
            for (int i = 0; i < 3; i++) begin
                if (aux_en_q[i]) begin
                    aux_clock_copy_out[i]      <= synth_clock_in[i];
                    aux_clock_copy_oe_n_out[i] <= 1'b0;
                end else begin
                    aux_clock_copy_out[i]      <= general_io_drive_in[i];
                    aux_clock_copy_oe_n_out[i] <= ~general_io_dir_in[i];
                end
            end
            for (int i = 3; i < 5; i++) begin
                aux_clock_copy_out[i]      <= aux_en_q[i] & synth_clock_in[i];
                aux_clock_copy_oe_n_out[i] <= ~aux_en_q[i];
            end
        end
    end

    // frame phase counters
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            cnt_8k_q <= '0;
            cnt_2k_q <= '0;
        end else begin
            cnt_8k_q <= (cnt_8k_q == LAST_8K) ? '0 : cnt_8k_q + 13'h0001;
            cnt_2k_q <= (cnt_2k_q == LAST_2K) ? '0 : cnt_2k_q + 13'h0001;
        end
    end

    // frame sync pins
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            frame_pulse_8k_out      <= 1'b0;
            multiframe_pulse_2k_out <= 1'b0;
        end else begin
            frame_pulse_8k_out      <= frame_level(cnt_8k_q, HALF_8K,
                                                   frame_ctl_q[`OPR_FRAME_PUL_8K],
                                                   frame_ctl_q[`OPR_FRAME_INV_8K]);
            multiframe_pulse_2k_out <= frame_level(cnt_2k_q, HALF_2K,
                                                   frame_ctl_q[`OPR_FRAME_PUL_2K],
                                                   frame_ctl_q[`OPR_FRAME_INV_2K]);
        end
    end

    chk_aux_gpio_copy: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
        aux_en_q[0] |=> (aux_clock_copy_out[0] == $past(synth_clock_in[0])
                         && !aux_clock_copy_oe_n_out[0]))
        else $error("aux one not copying clock one");
    chk_aux_reset_off: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
        $rose(strap_done_q) |-> (aux_en_q[2:0] == 3'h0))
        else $error("aux clock function on after reset");
    chk_aux_four_gate: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
        !aux_en_q[3] |=> (aux_clock_copy_oe_n_out[3] && !aux_clock_copy_out[3]))
        else $error("aux four active while disabled");
    chk_diff_pair_match: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
        diff_clock_plus_out[1:0] == {primary_clock_out_five_out, primary_clock_out_four_out}
        && diff_clock_minus_out[1:0] == ~diff_clock_plus_out[1:0])
        else $error("diff pair differs from single-ended");
    chk_diff_default_freq: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
        $rose(strap_done_q) |-> (freq_six_khz_out == `OPR_KHZ_38P88
                                 && diff_seven_format_sel_out == `OPR_FMT_LVDS))
        else $error("diff six/seven default wrong");
    chk_single_default: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
        $rose(strap_done_q) |-> (freq_one_khz_out == `OPR_KHZ_6P48
                                 && freq_four_khz_out == `OPR_KHZ_38P88))
        else $error("single-ended default wrong");
    chk_strap_five_freq: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
        $rose(strap_done_q) |-> (freq_five_khz_out == (rate_family_out
                                 ? `OPR_KHZ_1P544 : `OPR_KHZ_2P048)))
        else $error("output five default ignores strap");
    chk_frame_8k_edge: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
        (cnt_8k_q == HALF_8K && frame_ctl_q == 4'h0) |=> !frame_pulse_8k_out)
        else $error("8k clock not low at half period");
    chk_frame_8k_pulse: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
        (cnt_8k_q == PULSE_W && frame_ctl_q[`OPR_FRAME_PUL_8K]) |=>
            (frame_pulse_8k_out == $past(frame_ctl_q[`OPR_FRAME_INV_8K])))
        else $error("8k pulse width or polarity wrong");
    chk_frame_2k_start: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
        (cnt_2k_q == 13'h0000) |=> (multiframe_pulse_2k_out
                                    == !$past(frame_ctl_q[`OPR_FRAME_INV_2K])))
        else $error("2k sync wrong at period start");
    chk_strap_sample: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
        !strap_done_q |=> (rate_family_out == $past(rate_family_strap_in)))
        else $error("strap not latched at release");
    chk_aux_hiz_idle: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
        (!aux_en_q[1] && !general_io_dir_in[1]) |=> aux_clock_copy_oe_n_out[1])
        else $error("idle aux pin driven");

endmodule
`default_nettype wire

// file: rtl/opr_map.svh
// output clock pin routing: offsets-free constant map
// assumes inclusion by the design file and the bench only
`ifndef OPR_MAP_SVH
`define OPR_MAP_SVH
`define OPR_CLK_PERIOD_NS   100
`define OPR_FRAME_8K_NS     125000
`define OPR_FRAME_2K_NS     500000
`define OPR_PULSE_CYCLES    1
`define OPR_FMT_LVDS        2'h1
`define OPR_KHZ_6P48        20'h01950
`define OPR_KHZ_38P88       20'h097e0
`define OPR_KHZ_19P44       20'h04bf0
`define OPR_KHZ_1P544       20'h00608
`define OPR_KHZ_2P048       20'h00800
`define OPR_AUX_EN_RESET    5'h00
`define OPR_FRAME_CTL_RESET 4'h0
`define OPR_FRAME_INV_8K    0
`define OPR_FRAME_PUL_8K    1
`define OPR_FRAME_INV_2K    2
`define OPR_FRAME_PUL_2K    3
`endif

// file: rtl/opr_pkg.sv
// output clock pin routing: shared types
// assumes nothing beyond the constant map
package opr_pkg;
    typedef logic [1:0]  opr_fmt_t;
    typedef logic [19:0] opr_khz_t;
    typedef logic [12:0] opr_cnt_t;
    typedef enum logic {OPR_FAMILY_SDH, OPR_FAMILY_SONET} opr_family_e;
endpackage

// file: bench/opr_clock_consumer.sv
// far-side model: equipment on the three dual-use aux pins
// assumes the bench drives its own enables only where the device is an input
`timescale 1ns/10ps
`default_nettype none
module opr_clock_consumer (
    input  wire logic       mclk_in,
    input  wire logic [2:0] pin_val_in,
    input  wire logic [2:0] pin_oe_n_in,
    input  wire logic [2:0] ext_en_in,
    input  wire logic [2:0] ext_val_in,
    output logic      [2:0] pad_out
);
    logic [2:0] last_q = 3'h0;
    // an undriven pad toggles so a stale level never passes
    always @(posedge mclk_in) last_q <= pad_out;
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            pad_out[i] = !pin_oe_n_in[i] ? pin_val_in[i]
                       : ext_en_in[i] ? ext_val_in[i] : ~last_q[i];
        end
    end
endmodule
`default_nettype wire

// file: bench/opr_output_clock_pin_routing_tb.sv
// bench for output clock pin routing: random clocks, config and frame checks
// assumes the constant map header and the consumer model
`timescale 1ns/10ps
`default_nettype none
`include "opr_map.svh"
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin failures++; \
    $display("[FAIL] %s exp %h got %h", nm, e, g); end end
module opr_output_clock_pin_routing_tb;
    localparam int F8 = 10;
    localparam int F2 = 40;
    logic mclk_in = 1'b0, reset_n_in = 1'b0, strap = 1'b0, cfg_wr_in = 1'b0, freq_wr_in = 1'b0;
    logic [6:0] synth_clock_in = 7'h00;
    logic [4:0] aux_clock_enable_in = 5'h00, en_q, oe_n, aux;
    logic [7:0] diff_format_in = 8'h00, fmt_q;
    logic [3:0] frame_ctl_in = 4'h0, ctl_q, plus, minus;
    logic [2:0] freq_idx_in = 3'h0, drv = 3'h0, dir = 3'h0, ext_val = 3'h0, pad, pad_q, rd;
    wire  [4:0] prim;
    logic       live = 1'b0, f8, f2;
    opr_pkg::opr_khz_t freq_khz_in = 20'h00000, exp_f [7];
    wire opr_pkg::opr_khz_t got_f [7];
    wire opr_pkg::opr_fmt_t fm [4];
    opr_pkg::opr_family_e fam;
    int failures = 0, num_checks = 0, cycles = 0;
    logic [31:0] seed = 32'h1be0;

    opr_output_clock_pin_routing #(
        .FRAME_8K_CYCLES(F8), .FRAME_2K_CYCLES(F2), .PULSE_CYCLES(1)
    ) dut (
        .mclk_in(mclk_in), .reset_n_in(reset_n_in), .synth_clock_in(synth_clock_in),
        .rate_family_strap_in(strap), .cfg_wr_in(cfg_wr_in),
        .aux_clock_enable_in(aux_clock_enable_in),
        .diff_format_in(diff_format_in), .frame_ctl_in(frame_ctl_in), .freq_wr_in(freq_wr_in),
        .freq_idx_in(freq_idx_in), .freq_khz_in(freq_khz_in), .general_io_drive_in(drv),
        .general_io_dir_in(dir), .general_io_pad_in(pad), .general_io_read_out(rd),
        .primary_clock_out_one_out(prim[0]), .primary_clock_out_two_out(prim[1]),
        .primary_clock_out_three_out(prim[2]), .primary_clock_out_four_out(prim[3]),
        .primary_clock_out_five_out(prim[4]), .aux_clock_copy_out(aux),
        .aux_clock_copy_oe_n_out(oe_n),
        .diff_clock_plus_out(plus), .diff_clock_minus_out(minus), .diff_four_format_sel_out(fm[0]),
        .diff_five_format_sel_out(fm[1]), .diff_six_format_sel_out(fm[2]),
        .diff_seven_format_sel_out(fm[3]), .freq_one_khz_out(got_f[0]),
        .freq_two_khz_out(got_f[1]),
        .freq_three_khz_out(got_f[2]), .freq_four_khz_out(got_f[3]), .freq_five_khz_out(got_f[4]),
        .freq_six_khz_out(got_f[5]), .freq_seven_khz_out(got_f[6]), .rate_family_out(fam),
        .frame_pulse_8k_out(f8), .multiframe_pulse_2k_out(f2));
    opr_clock_consumer far_end (.mclk_in(mclk_in), .pin_val_in(aux[2:0]), .pin_oe_n_in(oe_n[2:0]),
        .ext_en_in(~dir & ~en_q[2:0]), .ext_val_in(ext_val), .pad_out(pad));

    initial begin
        forever #50 mclk_in = ~mclk_in;
    end
    always @(posedge mclk_in) pad_q <= pad;
    always @(posedge mclk_in) begin
        cycles++;
        if (cycles == 8000) begin
            failures++;
            wrap_up();
        end
    end

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic int exp_hi(int per, logic pul, logic inv);
        int h;
        h = (pul ? 1 : per / 2) * (40 / per);
        return inv ? 40 - h : h;
    endfunction

    task automatic check_pins();
        `CHK("primary", synth_clock_in[4:0], prim)
        `CHK("diff_plus", synth_clock_in[6:3], plus)
        `CHK("diff_minus", ~synth_clock_in[6:3], minus)
        `CHK("formats", fmt_q, {fm[3], fm[2], fm[1], fm[0]})
        `CHK("gpio_read", pad_q, rd)
        for (int i = 0; i < 7; i++) `CHK("freq", exp_f[i], got_f[i])
        for (int i = 0; i < 5; i++) begin
            if (en_q[i]) begin
                `CHK("aux_copy", {1'b0, synth_clock_in[i]}, {oe_n[i], aux[i]})
            end else if (i > 2) begin
                `CHK("aux_off", 2'b10, {oe_n[i], aux[i]})
            end else begin
                `CHK("gpio_oe_n", ~dir[i], oe_n[i])
                if (dir[i]) `CHK("gpio_val", drv[i], aux[i])
            end
        end
    endtask
    task automatic tick();
        logic [31:0] r;
        @(negedge mclk_in);
        if (live) check_pins();
        r = rnd();
        synth_clock_in = r[6:0];
    endtask
    task automatic cfg(input logic [2:0] idx, input opr_pkg::opr_khz_t khz);
        logic [31:0] r;
        r = rnd();
        live = 1'b0;
        {en_q, fmt_q, dir, drv, ext_val} = r[21:0];
        {aux_clock_enable_in, diff_format_in, frame_ctl_in} = {en_q, fmt_q, ctl_q};
        {cfg_wr_in, freq_wr_in, freq_idx_in, freq_khz_in} = {2'b11, idx, khz};
        tick();
        {cfg_wr_in, freq_wr_in} = 2'b00;
        if (idx != 3'h7) exp_f[idx] = khz;
        tick();
        tick();
        live = 1'b1;
    endtask
    task automatic frame_window();
        int n8;
        int n2;
        n8 = 0;
        n2 = 0;
        repeat (40) begin
            tick();
            n8 += (f8 === 1'b1);
            n2 += (f2 === 1'b1);
        end
        `CHK("frame_8k", exp_hi(F8, ctl_q[1], ctl_q[0]), n8)
        `CHK("frame_2k", exp_hi(F2, ctl_q[3], ctl_q[2]), n2)
    endtask
    task automatic do_reset(input logic s);
        live = 1'b0;
        reset_n_in = 1'b0;
        strap = s;
        {aux_clock_enable_in, diff_format_in, frame_ctl_in, dir} = {5'h1f, 8'h00, 4'hf, 3'h0};
        {en_q, fmt_q, ctl_q} = {5'h00, {4{`OPR_FMT_LVDS}}, 4'h0};
        repeat (20) tick();
        `CHK("oe_n_reset", 5'h1f, oe_n)
        reset_n_in = 1'b1;
        tick();
        tick();
        strap = ~s;
        exp_f = '{`OPR_KHZ_6P48, `OPR_KHZ_38P88, `OPR_KHZ_19P44, `OPR_KHZ_38P88,
                  s ? `OPR_KHZ_1P544 : `OPR_KHZ_2P048, `OPR_KHZ_38P88, `OPR_KHZ_19P44};
        `CHK("family", s, fam)
        live = 1'b1;
        frame_window();
    endtask
    task automatic wrap_up();
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    initial begin
        logic [31:0] r;
        do_reset(1'b0);
        for (int k = 0; k < 16; k++) begin
            ctl_q = k[3:0];
            r = rnd();
            cfg(r[22:20], r[19:0]);
            frame_window();
        end
        do_reset(1'b1);
        for (int k = 0; k < 24; k++) begin
            r = rnd();
            cfg((k == 0) ? 3'h7 : r[22:20], r[19:0]);
            repeat (6) tick();
        end
        wrap_up();
    end
endmodule
`default_nettype wire
